/* rtl/sdaci_top.sv */
`timescale 1ns/100ps
`include "sdaci_cfg.svh"

module sdaci_top (
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire sdaci_pkg::sdaci_pins_type pins,
	output logic                         serial_out_o,
	output logic                         serial_out_oe,
	output logic [15:0]                  vout_code,
	output logic                         vout_ground,
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [7:0]              awaddr,
	input  wire logic                    wvalid,
	output logic                         wready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	output logic                         bvalid,
	input  wire logic                    bready,
	output logic [1:0]                   bresp,
	input  wire logic                    arvalid,
	output logic                         arready,
	input  wire logic [7:0]              araddr,
	output logic                         rvalid,
	input  wire logic                    rready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp
);
	import sdaci_pkg::*;

	function automatic logic fell(input logic p, input logic c);
		return p & ~c;
	endfunction : fell
	function automatic logic rose(input logic p, input logic c);
		return ~p & c;
	endfunction : rose
	function automatic logic addr_known(input logic [7:0] a);
		return (a == `SDACI_ADDR_CTRL) || (a == `SDACI_ADDR_STATUS) ||
			(a == `SDACI_ADDR_INREG) || (a == `SDACI_ADDR_DACREG) ||
			(a == `SDACI_ADDR_OUTCODE);
	endfunction : addr_known

	sdaci_pins_type              s1_ff;
	sdaci_pins_type              s2_ff;
	sdaci_pins_type              s3_ff;
	sdaci_pins_type              cur_ff;
	sdaci_pins_type              prv_ff;
	sdaci_state_type             st_ff;
	logic [15:0]                 sr_ff;
	logic [15:0]                 nxt_sr;
	logic [`SDACI_CNT_W-1:0]     cnt_ff;
	logic [15:0]                 in_ff;
	logic [15:0]                 dac_ff;
	logic                        zero_ff;
	logic                        gnd_ff;
	logic [15:0]                 code_ff;
	logic                        oe_ff;
	logic                        force_gnd_ff;
	logic                        sync_fall;
	logic                        sync_rise;
	logic                        sclk_fall;
	logic                        load_output_n_fall;
	logic                        clr_fall;
	logic                        in_frame;
	logic                        shift_en;
	logic                        full;
	logic                        word_end;
	logic                        sync_load;
	logic                        async_load;
	logic                        ground;
	logic                        aw_ok_ff;
	logic [7:0]                  aw_addr_ff;
	logic                        w_ok_ff;
	logic [31:0]                 w_data_ff;
	logic                        w_lane0_ff;
	logic                        bvalid_ff;
	logic [1:0]                  bresp_ff;
	logic                        rvalid_ff;
	logic [31:0]                 rdata_ff;
	logic [1:0]                  rresp_ff;
	logic                        do_wr;
	logic [31:0]                 rd_word;
	logic [31:0]                 status_word;

	// pin synchronisers: a level counts once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur_ff <= '1;
			prv_ff <= '1;
		end else begin
			cur_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (cur_ff & (s2_ff ^ s3_ff));
			prv_ff <= cur_ff;
		end
	end

	assign sync_fall = fell(prv_ff.sync_n, cur_ff.sync_n);
	assign sync_rise = rose(prv_ff.sync_n, cur_ff.sync_n);
	assign sclk_fall = fell(prv_ff.sclk, cur_ff.sclk);
	assign load_output_n_fall = fell(prv_ff.load_output_n, cur_ff.load_output_n);
	assign clr_fall  = fell(prv_ff.zero_output_n, cur_ff.zero_output_n);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff <= SDACI_IDLE;
		end else begin
			case (st_ff)
				SDACI_IDLE: begin
					if (sync_fall) begin
						st_ff <= SDACI_FRAME;
					end
				end
				SDACI_FRAME: begin
					if (sync_rise) begin
						st_ff <= SDACI_IDLE;
					end
				end
				default: begin
					st_ff <= SDACI_IDLE;
				end
			endcase
		end
	end
	assign in_frame = (st_ff == SDACI_FRAME);
	// a clock fall in the frame's closing cycle is ignored
	assign shift_en = in_frame && sclk_fall && !sync_rise;
	assign full     = (cnt_ff == `SDACI_CNT_W'(`SDACI_WORD_BITS));
	assign word_end = in_frame && sync_rise && full;
	// frame start loads the DAC register for readback
	always_comb begin
		nxt_sr = sr_ff;
		if (sync_fall) begin
			nxt_sr = dac_ff;
		end else if (shift_en) begin
			nxt_sr = {sr_ff[14:0], cur_ff.serial_in};
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sr_ff <= `SDACI_MIDSCALE;
		end else begin
			sr_ff <= nxt_sr;
		end
	end
	// count saturates: a longer frame keeps the last sixteen bits
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_ff <= '0;
		end else if (sync_fall) begin
			cnt_ff <= '0;
		end else if (shift_en && !full) begin
			cnt_ff <= cnt_ff + `SDACI_CNT_W'(1);
		end
	end
	// a short frame never reaches here
	always_ff @(posedge core_clk) begin
		if (rst) begin
			in_ff <= `SDACI_MIDSCALE;
		end else if (word_end) begin
			in_ff <= sr_ff;
		end
	end
	assign sync_load  = word_end && !cur_ff.load_output_n;
	// asynchronous update while frame is idle
	assign async_load = load_output_n_fall && !in_frame && cur_ff.sync_n;

	// clear and power-down do not block register writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dac_ff <= `SDACI_MIDSCALE;
		end else if (sync_load) begin
			dac_ff <= sr_ff;
		end else if (async_load) begin
			dac_ff <= in_ff;
		end
	end
	// clear latch: set wins, released by the next strobe low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			zero_ff <= 1'b0;
		end else if (!cur_ff.zero_output_n) begin
			zero_ff <= 1'b1;
		end else if (load_output_n_fall || sync_load) begin
			zero_ff <= 1'b0;
		end
	end
	assign ground = force_gnd_ff || zero_ff || !cur_ff.zero_output_n ||
		!cur_ff.low_power_n;
	// straight binary: midscale is zero volts
	// output at ground while in reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			gnd_ff  <= 1'b1;
			code_ff <= `SDACI_MIDSCALE;
		end else begin
			gnd_ff  <= ground;
			code_ff <= ground ? `SDACI_MIDSCALE : dac_ff;
		end
	end

	// bits leaving the top ripple out here
	always_ff @(posedge core_clk) begin
		if (rst) begin
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= !nxt_sr[15] && cur_ff.low_power_n;
		end
	end

	assign serial_out_o  = 1'b0;
	assign serial_out_oe = oe_ff;
	assign vout_code     = code_ff;
	assign vout_ground   = gnd_ff;

	// bus write side: address and data taken in either order
	assign awready = !aw_ok_ff && !bvalid_ff;
	assign wready  = !w_ok_ff && !bvalid_ff;
	assign do_wr   = aw_ok_ff && w_ok_ff && !bvalid_ff;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_ok_ff   <= 1'b0;
			aw_addr_ff <= '0;
		end else if (awvalid && awready) begin
			aw_ok_ff   <= 1'b1;
			aw_addr_ff <= awaddr;
		end else if (do_wr) begin
			aw_ok_ff   <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			w_ok_ff    <= 1'b0;
			w_data_ff  <= '0;
			w_lane0_ff <= 1'b0;
		end else if (wvalid && wready) begin
			w_ok_ff    <= 1'b1;
			w_data_ff  <= wdata;
			w_lane0_ff <= wstrb[0];
		end else if (do_wr) begin
			w_ok_ff    <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `SDACI_RESP_OKAY;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= addr_known(aw_addr_ff) ? `SDACI_RESP_OKAY : `SDACI_RESP_SLVERR;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// only the control word is writable; the rest ignore writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			force_gnd_ff <= `SDACI_CTRL_RST;
		end else if (do_wr && w_lane0_ff && aw_addr_ff == `SDACI_ADDR_CTRL) begin
			force_gnd_ff <= w_data_ff[`SDACI_CTRL_GND_BIT];
		end
	end

	assign bvalid = bvalid_ff;
	assign bresp  = bresp_ff;

	always_comb begin
		status_word = '0;
		status_word[`SDACI_ST_FRAME_BIT] = in_frame;
		status_word[`SDACI_ST_ZERO_BIT]  = zero_ff;
		status_word[`SDACI_ST_PD_BIT]    = !cur_ff.low_power_n;
		status_word[`SDACI_ST_SDO_BIT]   = cur_ff.serial_out_i;
		status_word[`SDACI_ST_GND_BIT]   = gnd_ff;
		status_word[`SDACI_ST_CNT_LSB +: `SDACI_CNT_W] = cnt_ff;
	end

	always_comb begin
		case (araddr)
			`SDACI_ADDR_CTRL: begin
				rd_word = {31'h0, force_gnd_ff};
			end
			`SDACI_ADDR_STATUS: begin
				rd_word = status_word;
			end
			`SDACI_ADDR_INREG: begin
				rd_word = {16'h0, in_ff};
			end
			`SDACI_ADDR_DACREG: begin
				rd_word = {16'h0, dac_ff};
			end
			`SDACI_ADDR_OUTCODE: begin
				rd_word = {16'h0, code_ff};
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	assign arready = !rvalid_ff;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= `SDACI_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= addr_known(araddr) ? `SDACI_RESP_OKAY : `SDACI_RESP_SLVERR;
		end else if (rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign rvalid = rvalid_ff;
	assign rdata  = rdata_ff;
	assign rresp  = rresp_ff;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_word_end;
		in_frame && sync_rise && full;
	endsequence
	sequence s_sync_word;
		s_word_end and !cur_ff.load_output_n;
	endsequence
	midscale_reset_a: assert property ($fell(rst) |-> in_ff == `SDACI_MIDSCALE && dac_ff == `SDACI_MIDSCALE)
		else $error("registers not midscale after reset");
	frame_ignore_a: assert property ($changed(sr_ff) |-> $past(in_frame) || $past(sync_fall))
		else $error("shift register moved outside a frame");
	shift_fall_a: assert property (shift_en |=> sr_ff == {$past(sr_ff[14:0]), $past(cur_ff.serial_in)})
		else $error("bad shift on clock fall");
	auto_copy_a: assert property (s_word_end |=> in_ff == $past(sr_ff))
		else $error("input register missed word");
	partial_drop_a: assert property (in_frame && sync_rise && !full |=> $stable(in_ff))
		else $error("partial word reached input register");
	sync_update_a: assert property (s_sync_word |=> dac_ff == $past(sr_ff))
		else $error("synchronous update missed");
	async_update_a: assert property (load_output_n_fall && st_ff == SDACI_IDLE && cur_ff.sync_n |=> dac_ff == $past(in_ff))
		else $error("asynchronous update missed");
	clear_hold_a: assert property (!cur_ff.zero_output_n ##1 cur_ff.zero_output_n && !load_output_n_fall
		|=> vout_ground && vout_code == `SDACI_MIDSCALE)
		else $error("output left ground after clear");
	pd_ground_a: assert property (!cur_ff.low_power_n |=> vout_ground ##0 !serial_out_oe)
		else $error("power-down not honoured");
	readback_a: assert property (sync_fall |=> sr_ff == $past(dac_ff) ##0
		serial_out_oe == (!$past(dac_ff[15]) && $past(cur_ff.low_power_n)))
		else $error("readback not presented");
	clear_keep_a: assert property (clr_fall && !word_end && !async_load |=> $stable(dac_ff) && $stable(in_ff))
		else $error("clear disturbed registers");
endmodule : sdaci_top

/* rtl/sdaci_cfg.svh */
`ifndef SDACI_CFG_SVH
`define SDACI_CFG_SVH

// word framing
`define SDACI_WORD_BITS 16
`define SDACI_CNT_W 5
`define SDACI_MIDSCALE 16'h8000

// register byte addresses
`define SDACI_ADDR_CTRL 8'h00
`define SDACI_ADDR_STATUS 8'h04
`define SDACI_ADDR_INREG 8'h08
`define SDACI_ADDR_DACREG 8'h0c
`define SDACI_ADDR_OUTCODE 8'h10

// control fields
`define SDACI_CTRL_GND_BIT 0
`define SDACI_CTRL_RST 1'b0

// status fields
`define SDACI_ST_FRAME_BIT 0
`define SDACI_ST_ZERO_BIT 1
`define SDACI_ST_PD_BIT 2
`define SDACI_ST_SDO_BIT 3
`define SDACI_ST_GND_BIT 4
`define SDACI_ST_CNT_LSB 8

// bus answers
`define SDACI_RESP_OKAY 2'b00
`define SDACI_RESP_SLVERR 2'b10

`endif

/* rtl/sdaci_pkg.sv */
package sdaci_pkg;

	// pin group, sampled together through the synchronisers
	typedef struct packed {
		logic sync_n;
		logic sclk;
		logic serial_in;
		logic load_output_n;
		logic zero_output_n;
		logic low_power_n;
		logic serial_out_i;
	} sdaci_pins_type;

	typedef enum logic [1:0] {
		SDACI_IDLE  = 2'b01,
		SDACI_FRAME = 2'b10
	} sdaci_state_type;

endpackage : sdaci_pkg

/* sim/sdaci_host_model.sv */
`timescale 1ns/100ps
module sdaci_host_model (
	input  wire logic core_clk,
	input  wire logic serial_out_oe,
	input  wire logic serial_out_o,
	output logic      sync_n,
	output logic      sclk,
	output logic      serial_in,
	output logic      wire_lvl
);
	assign wire_lvl = serial_out_oe ? serial_out_o : 1'b1;

	initial begin
		sync_n = 1'b1;
		sclk = 1'b1;
		serial_in = 1'b0;
	end

	// half link period is 6 core clocks (48 ns period); clock parks high outside frames
	task automatic frame(input logic [31:0] d, input int n, input logic framed, output logic [31:0] rb);
		rb = '0;
		sync_n <= ~framed;
		repeat (12) @(posedge core_clk);
		for (int i = n - 1; i >= 0; i--) begin
			serial_in <= d[i];
			repeat (6) @(posedge core_clk);
			rb = {rb[30:0], wire_lvl};
			sclk <= 1'b0;
			repeat (6) @(posedge core_clk);
			sclk <= 1'b1;
		end
		repeat (6) @(posedge core_clk);
		sync_n <= 1'b1;
		// data line is undriven now, so show a changed level rather than the last bit
		serial_in <= ~serial_in;
		repeat (40) @(posedge core_clk);
	endtask : frame
endmodule : sdaci_host_model

/* sim/sdaci_top_test.sv */
`timescale 1ns/100ps
`include "sdaci_cfg.svh"
module sdaci_top_test;
	import sdaci_pkg::*;
	logic           core_clk, rst, load_output_n, zero_output_n, low_power_n;
	logic           sync_n, sclk, serial_in, wire_lvl, serial_out_oe, serial_out_o, vout_ground;
	logic           awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]     awaddr, araddr;
	logic [31:0]    wdata, rdata, rb, rd_d;
	logic [15:0]    vout_code;
	logic [3:0]     wstrb;
	logic [1:0]     bresp, rresp, rs;
	sdaci_pins_type pins;
	int             miscompares, comparisons;

	assign pins = {sync_n, sclk, serial_in, load_output_n, zero_output_n, low_power_n, wire_lvl};

	sdaci_top i_dut (
		.core_clk, .rst, .pins, .serial_out_o, .serial_out_oe, .vout_code, .vout_ground,
		.awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp
	);

	sdaci_host_model i_host (.core_clk, .serial_out_oe, .serial_out_o, .sync_n, .sclk, .serial_in, .wire_lvl);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check("bresp", 32'(er), 32'(bresp));
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(what, e, d);
		check("rresp", 32'(`SDACI_RESP_OKAY), 32'(r));
	endtask : rd_chk

	task automatic out_chk(input logic [15:0] code, input logic gnd);
		check("vout_code", {16'h0, code}, {16'h0, vout_code});
		check("vout_ground", {31'h0, gnd}, {31'h0, vout_ground});
	endtask : out_chk

	task automatic end_of_test;
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		end_of_test();
	end

	initial begin
		{rst, load_output_n, zero_output_n, low_power_n} = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		repeat (2) @(posedge core_clk);
		out_chk(16'h8000, 1'b1);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		rd_chk("inreg", `SDACI_ADDR_INREG, 32'h8000);
		rd_chk("dacreg", `SDACI_ADDR_DACREG, 32'h8000);
		rd_chk("ctrl", `SDACI_ADDR_CTRL, 32'h0);
		rd_chk("status", `SDACI_ADDR_STATUS, 32'h8);
		rd(8'h20, rd_d, rs);
		check("unmapped rresp", 32'(`SDACI_RESP_SLVERR), 32'(rs));
		check("unmapped rdata", 32'h0, rd_d);
		wr(8'h20, 32'h1, `SDACI_RESP_SLVERR);
		wr(`SDACI_ADDR_INREG, 32'hffff, `SDACI_RESP_OKAY);
		rd_chk("inreg", `SDACI_ADDR_INREG, 32'h8000);
		wr(`SDACI_ADDR_CTRL, 32'h1, `SDACI_RESP_OKAY);
		repeat (4) @(posedge core_clk);
		check("forced ground", 32'h1, {31'h0, vout_ground});
		rd_chk("ctrl", `SDACI_ADDR_CTRL, 32'h1);
		wr(`SDACI_ADDR_CTRL, 32'h0, `SDACI_RESP_OKAY);
		load_output_n <= 1'b0;
		i_host.frame(32'hffff, 16, 1'b1, rb);
		out_chk(16'hffff, 1'b0);
		rd_chk("status", `SDACI_ADDR_STATUS, 32'h1008);
		rd_chk("outcode", `SDACI_ADDR_OUTCODE, 32'hffff);
		i_host.frame(32'hc3a5, 16, 1'b1, rb);
		out_chk(16'hc3a5, 1'b0);
		load_output_n <= 1'b1;
		i_host.frame(32'h5a3c, 16, 1'b1, rb);
		rd_chk("inreg", `SDACI_ADDR_INREG, 32'h5a3c);
		rd_chk("dacreg", `SDACI_ADDR_DACREG, 32'hc3a5);
		out_chk(16'hc3a5, 1'b0);
		load_output_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		out_chk(16'h5a3c, 1'b0);
		load_output_n <= 1'b1;
		i_host.frame(32'h1e87_9b40, 32, 1'b1, rb);
		check("readback", 32'h5a3c_1e87, rb);
		rd_chk("inreg", `SDACI_ADDR_INREG, 32'h9b40);
		rd_chk("dacreg", `SDACI_ADDR_DACREG, 32'h5a3c);
		i_host.frame(32'h66, 8, 1'b1, rb);
		rd_chk("inreg", `SDACI_ADDR_INREG, 32'h9b40);
		i_host.frame(32'h1111, 16, 1'b0, rb);
		rd_chk("inreg", `SDACI_ADDR_INREG, 32'h9b40);
		zero_output_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		check("cleared", 32'h1, {31'h0, vout_ground});
		rd_chk("inreg", `SDACI_ADDR_INREG, 32'h9b40);
		rd_chk("dacreg", `SDACI_ADDR_DACREG, 32'h5a3c);
		rd_chk("status", `SDACI_ADDR_STATUS, 32'h812);
		load_output_n <= 1'b0;
		i_host.frame(32'h4d2e, 16, 1'b1, rb);
		rd_chk("dacreg", `SDACI_ADDR_DACREG, 32'h4d2e);
		check("cleared", 32'h1, {31'h0, vout_ground});
		load_output_n <= 1'b1;
		i_host.frame(32'h2b71, 16, 1'b1, rb);
		rd_chk("inreg", `SDACI_ADDR_INREG, 32'h2b71);
		rd_chk("dacreg", `SDACI_ADDR_DACREG, 32'h4d2e);
		zero_output_n <= 1'b1;
		repeat (12) @(posedge core_clk);
		check("cleared", 32'h1, {31'h0, vout_ground});
		load_output_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		out_chk(16'h2b71, 1'b0);
		load_output_n <= 1'b1;
		low_power_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		check("powered down", 32'h1, {31'h0, vout_ground});
		load_output_n <= 1'b0;
		i_host.frame(32'h6a5d, 16, 1'b1, rb);
		check("readback", 32'hffff, rb);
		rd_chk("dacreg", `SDACI_ADDR_DACREG, 32'h6a5d);
		check("powered down", 32'h1, {31'h0, vout_ground});
		rd_chk("status", `SDACI_ADDR_STATUS, 32'h101c);
		rd_chk("outcode", `SDACI_ADDR_OUTCODE, 32'h8000);
		end_of_test();
	end
endmodule : sdaci_top_test
